// *** verilog/ffc_top.v ***
// frame fifo controller: tx enable/disable/reset, fifo sizing, occupancy, pause watermarks
// assumes one clock, avalon-mm register access, mac and usb stages synchronous to clk_sys
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "ffc_map.vh"

module ffc_top #(
  parameter LEN_W   = 14,
  parameter EXTRA_W = 8,
  parameter Q_DEPTH = 16,
  parameter Q_PTR_W = 4
) (
  // clock, reset, enable
  input  wire               clk_sys,
  input  wire               sys_rst,
  input  wire               clkEn,
  // avalon-mm slave
  input  wire [7:0]         avs_address,
  input  wire               avs_read,
  input  wire               avs_write,
  input  wire [31:0]        avs_writedata,
  input  wire [3:0]         avs_byteenable,
  output reg  [31:0]        avs_readdata,
  output reg                avs_waitrequest,
  // usb staging fifo occupancy
  input  wire [15:0]        usbOutStageBytes,
  input  wire [15:0]        usbInStageBytes,
  // tx frame store from usb side
  input  wire               txFrameWr,
  input  wire [LEN_W-1:0]   txFrameLen,
  input  wire [EXTRA_W-1:0] txFrameExtra,
  output reg                txWrReady_r,
  output reg                usbInFlush_r,
  // mac transmit
  input  wire               macTxReq,
  input  wire               macTxDone,
  input  wire               macTxRetry,
  input  wire               halfDuplex,
  output reg                txStart_r,
  output reg                txActive_r,
  output reg                txDiscard_r,
  // mac receive store and usb drain
  input  wire               rxFrameWr,
  input  wire [LEN_W-1:0]   rxFrameLen,
  input  wire [EXTRA_W-1:0] rxFrameExtra,
  input  wire               rxFrameRd,
  output reg                rxWrReady_r,
  // pause frame request
  output reg                pauseReq_r
);

  // tx control states
  localparam [1:0]           ST_OFF   = 2'h0;
  localparam [1:0]           ST_ON    = 2'h1;
  localparam [1:0]           ST_DRAIN = 2'h2;

  reg  [1:0]                 ctlState_r;
  reg                        txEnable_r;
  reg                        txRst_r;
  reg                        txDisabled_r;
  reg  [`FFC_RX_END_W-1:0]   rxEnd_r;
  reg  [`FFC_TX_END_W-1:0]   txEnd_r;
  reg  [`FFC_WM_W-1:0]       wmOn_r;
  reg  [`FFC_WM_W-1:0]       wmOff_r;
  wire                       busAct;
  wire                       wrAct;
  wire                       rdAct;
  wire [15:0]                tx_fifo_bytes_used;
  wire [15:0]                rx_fifo_bytes_used;
  wire                       txQNotFull;
  wire                       txQNotEmpty;
  wire                       rxQNotFull;
  wire                       txDiscardEv;
  wire                       txPop;
  wire                       txStartEv;
  wire                       disableDone;
  wire [`FFC_WM_W-1:0]       rxUnits;
  wire [31:0]                wmMerged;
  wire [31:0]                rxEndMerged;
  wire [31:0]                txEndMerged;
  reg  [31:0]                rdMux;

  // byte-lane merge of a write into a register image
  function [31:0] beMerge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer      i;
    begin
      beMerge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          beMerge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction

  // fifo capacity in bytes: (field*128+127+1) dwords
  function [16:0] capBytes;
    input [6:0] endField;
    begin
      capBytes = {1'b0, endField, 9'h000} + 17'h00200;
    end
  endfunction

  // combined path occupancy, saturating to the 16-bit field
  function [15:0] addSat16;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s        = {1'b0, a} + {1'b0, b};
      addSat16 = s[16] ? 16'hffff : s[15:0];
    end
  endfunction

  // bus handshake: one wait cycle, then waitrequest low for one cycle
  assign busAct = (avs_read | avs_write) & avs_waitrequest & clkEn;
  assign wrAct  = busAct & avs_write;
  assign rdAct  = busAct & avs_read & ~avs_write;

  assign wmMerged    = beMerge({17'h0, wmOff_r, 1'b0, wmOn_r}, avs_writedata, avs_byteenable);
  assign rxEndMerged = beMerge({25'h0, rxEnd_r}, avs_writedata, avs_byteenable);
  assign txEndMerged = beMerge({26'h0, txEnd_r}, avs_writedata, avs_byteenable);

  // mac transmit sequencing
  assign txStartEv   = (ctlState_r == ST_ON) & txEnable_r & ~txActive_r & txQNotEmpty
                       & macTxReq & ~txRst_r;
  assign txDiscardEv = txActive_r & macTxRetry & ~macTxDone & halfDuplex & ~txEnable_r;
  assign txPop       = txActive_r & (macTxDone | txDiscardEv) & ~txRst_r;
  assign disableDone = (ctlState_r == ST_DRAIN) & ~txActive_r;

  ffc_charge_q #(
    .LEN_W     (LEN_W),
    .EXTRA_W   (EXTRA_W),
    .DEPTH     (Q_DEPTH),
    .PTR_W     (Q_PTR_W)
  ) txQueue (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clkEn     (clkEn),
    .flush     (txRst_r),
    .push      (txFrameWr),
    .pushLen   (txFrameLen),
    .pushExtra (txFrameExtra),
    .pop       (txPop),
    .usedBytes (tx_fifo_bytes_used),
    .notFull   (txQNotFull),
    .notEmpty  (txQNotEmpty)
  );

  ffc_charge_q #(
    .LEN_W     (LEN_W),
    .EXTRA_W   (EXTRA_W),
    .DEPTH     (Q_DEPTH),
    .PTR_W     (Q_PTR_W)
  ) rxQueue (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clkEn     (clkEn),
    .flush     (1'b0),
    .push      (rxFrameWr),
    .pushLen   (rxFrameLen),
    .pushExtra (rxFrameExtra),
    .pop       (rxFrameRd),
    .usedBytes (rx_fifo_bytes_used),
    .notFull   (rxQNotFull),
    .notEmpty  ()
  );

  assign rxUnits = rx_fifo_bytes_used[15:`FFC_UNIT_SHIFT];

  // register read mux; unmapped offsets read zero
  always @*
  begin
    rdMux = 32'h0000_0000;
    if (avs_address == `FFC_OFF_TX_CTL)
    begin
      rdMux[`FFC_TXEN_BIT]  = txEnable_r;
      rdMux[`FFC_TXRST_BIT] = txRst_r;
      rdMux[`FFC_TXDIS_BIT] = txDisabled_r;
      rdMux[`FFC_USED_HI:0] = tx_fifo_bytes_used;
    end
    else if (avs_address == `FFC_OFF_RX_END)
      rdMux[`FFC_RX_END_W-1:0] = rxEnd_r;
    else if (avs_address == `FFC_OFF_TX_END)
      rdMux[`FFC_TX_END_W-1:0] = txEnd_r;
    else if (avs_address == `FFC_OFF_FLOW_WM)
    begin
      rdMux[`FFC_WM_ON_LO +: `FFC_WM_W]  = wmOn_r;
      rdMux[`FFC_WM_OFF_LO +: `FFC_WM_W] = wmOff_r;
    end
    else if (avs_address == `FFC_OFF_RX_PATH)
      rdMux = {addSat16(usbOutStageBytes, rx_fifo_bytes_used), usbOutStageBytes};
    else if (avs_address == `FFC_OFF_TX_PATH)
      rdMux = {addSat16(usbInStageBytes, tx_fifo_bytes_used), usbInStageBytes};
  end

  // bus slave and configuration registers
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      rxEnd_r         <= `FFC_RX_END_RST;
      txEnd_r         <= `FFC_TX_END_RST;
      wmOn_r          <= `FFC_WM_RST;
      wmOff_r         <= `FFC_WM_RST;
    end
    else if (clkEn)
    begin
      avs_waitrequest <= ~busAct;
      if (rdAct)
        avs_readdata <= rdMux;
      if (wrAct)
      begin
        if (avs_address == `FFC_OFF_RX_END)
          rxEnd_r <= rxEndMerged[`FFC_RX_END_W-1:0];
        else if (avs_address == `FFC_OFF_TX_END)
          txEnd_r <= txEndMerged[`FFC_TX_END_W-1:0];
        else if (avs_address == `FFC_OFF_FLOW_WM)
        begin
          wmOn_r  <= wmMerged[`FFC_WM_ON_LO +: `FFC_WM_W];
          wmOff_r <= wmMerged[`FFC_WM_OFF_LO +: `FFC_WM_W];
        end
      end
    end
  end

  // tx control: enable, self-clearing reset, disable sequence
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      txEnable_r   <= 1'b0;
      txRst_r      <= 1'b0;
      txDisabled_r <= 1'b0;
      usbInFlush_r <= 1'b0;
      ctlState_r   <= ST_OFF;
    end
    else if (clkEn)
    begin
      // reset bit stands one cycle, then reads back zero
      txRst_r      <= wrAct & (avs_address == `FFC_OFF_TX_CTL) & avs_byteenable[3]
                      & avs_writedata[`FFC_TXRST_BIT];
      usbInFlush_r <= txRst_r;
      if (wrAct && (avs_address == `FFC_OFF_TX_CTL) && avs_byteenable[3])
        txEnable_r <= avs_writedata[`FFC_TXEN_BIT];
      // set beats a same-cycle write-one clear
      if (disableDone)
        txDisabled_r <= 1'b1;
      else if (wrAct && (avs_address == `FFC_OFF_TX_CTL) && avs_byteenable[2]
               && avs_writedata[`FFC_TXDIS_BIT])
        txDisabled_r <= 1'b0;
      case (ctlState_r)
        ST_OFF:
          if (txEnable_r)
            ctlState_r <= ST_ON;
        ST_ON:
          if (!txEnable_r)
            ctlState_r <= ST_DRAIN;
        ST_DRAIN:
          if (txEnable_r)
            ctlState_r <= ST_ON;
          else if (disableDone)
            ctlState_r <= ST_OFF;
        default:
          ctlState_r <= ST_OFF;
      endcase
    end
  end

  // mac transmit side
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      txStart_r   <= 1'b0;
      txActive_r  <= 1'b0;
      txDiscard_r <= 1'b0;
    end
    else if (clkEn)
    begin
      txStart_r   <= txStartEv;
      txDiscard_r <= txDiscardEv & ~txRst_r;
      if (txRst_r)
        txActive_r <= 1'b0;
      else if (txStartEv)
        txActive_r <= 1'b1;
      else if (txPop)
        txActive_r <= 1'b0;
    end
  end

  // space flags, pause hysteresis
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      txWrReady_r <= 1'b0;
      rxWrReady_r <= 1'b0;
      pauseReq_r  <= 1'b0;
    end
    else if (clkEn)
    begin
      // one cycle of lag: the queue itself drops a push when full
      txWrReady_r <= txQNotFull & ~txRst_r & ({1'b0, tx_fifo_bytes_used} < capBytes({1'b0, txEnd_r}));
      rxWrReady_r <= rxQNotFull & ({1'b0, rx_fifo_bytes_used} < capBytes(rxEnd_r));
      if (!pauseReq_r && (rxUnits >= wmOn_r))
        pauseReq_r <= 1'b1;
      else if (pauseReq_r && (rxUnits <= wmOff_r))
        pauseReq_r <= 1'b0;
    end
  end

endmodule // ffc_top

// *** verilog/ffc_map.vh ***
// register map, field positions and reset values of the frame fifo controller
// assumes byte addressing on a 32-bit avalon-mm slave port
`ifndef FFC_MAP_VH
`define FFC_MAP_VH

// register byte offsets
`define FFC_OFF_TX_CTL     8'hc4
`define FFC_OFF_RX_END     8'hc8
`define FFC_OFF_TX_END     8'hcc
`define FFC_OFF_FLOW_WM    8'hd0
`define FFC_OFF_RX_PATH    8'hd4
`define FFC_OFF_TX_PATH    8'hd8

// tx_fifo_control fields
`define FFC_TXEN_BIT       31
`define FFC_TXRST_BIT      30
`define FFC_TXDIS_BIT      20
`define FFC_USED_HI        15

// end-address fields
`define FFC_RX_END_W       7
`define FFC_TX_END_W       6
`define FFC_RX_END_RST     7'h17
`define FFC_TX_END_RST     6'h17

// flow_watermarks fields
`define FFC_WM_ON_LO       0
`define FFC_WM_OFF_LO      8
`define FFC_WM_W           7
`define FFC_WM_RST         7'h00

// watermark unit is 512 bytes, one end-field step is 128 dwords = 512 bytes
`define FFC_UNIT_SHIFT     9

`endif

// *** verilog/ffc_charge_q.v ***
// per-frame byte-charge queue with a running byte-occupancy count
// assumes push and pop are one-cycle pulses synchronous to clk_sys
`timescale 1ns/1ps

module ffc_charge_q #(
  parameter LEN_W   = 14,
  parameter EXTRA_W = 8,
  parameter DEPTH   = 16,
  parameter PTR_W   = 4
) (
  // clock, reset, enable
  input  wire               clk_sys,
  input  wire               sys_rst,
  input  wire               clkEn,
  input  wire               flush,
  // frame stored
  input  wire               push,
  input  wire [LEN_W-1:0]   pushLen,
  input  wire [EXTRA_W-1:0] pushExtra,
  // frame released
  input  wire               pop,
  // state
  output wire [15:0]        usedBytes,
  output wire               notFull,
  output wire               notEmpty
);

  localparam [PTR_W:0] FULL_CNT = DEPTH[PTR_W:0];

  reg  [15:0]      mem [0:DEPTH-1];
  reg  [PTR_W-1:0] wrPtr_r;
  reg  [PTR_W-1:0] rdPtr_r;
  reg  [PTR_W:0]   count_r;
  reg  [15:0]      used_r;
  reg  [15:0]      used_nxt;
  wire             pushOk;
  wire             popOk;
  wire [15:0]      pushCharge;

  // length padded to a dword plus stored command words and checksums
  function [15:0] frameCharge;
    input [LEN_W-1:0]   len;
    input [EXTRA_W-1:0] extra;
    reg   [15:0]        padded;
    begin
      padded      = ({{(16-LEN_W){1'b0}}, len} + 16'h0003) & 16'hfffc;
      frameCharge = padded + {{(16-EXTRA_W){1'b0}}, extra};
    end
  endfunction

  assign pushCharge = frameCharge(pushLen, pushExtra);
  // a push into a full queue is dropped; the source must watch notFull
  assign pushOk     = push & (count_r != FULL_CNT);
  assign popOk      = pop & (count_r != {(PTR_W+1){1'b0}});
  assign notFull    = (count_r != FULL_CNT);
  assign notEmpty   = (count_r != {(PTR_W+1){1'b0}});
  assign usedBytes  = used_r;

  always @*
  begin
    used_nxt = used_r;
    if (pushOk)
      used_nxt = used_nxt + pushCharge;
    if (popOk)
      used_nxt = used_nxt - mem[rdPtr_r];
  end

  always @(posedge clk_sys)
  begin
    if (pushOk && clkEn && !sys_rst && !flush)
      mem[wrPtr_r] <= pushCharge;
  end

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wrPtr_r <= {PTR_W{1'b0}};
      rdPtr_r <= {PTR_W{1'b0}};
      count_r <= {(PTR_W+1){1'b0}};
      used_r  <= 16'h0000;
    end
    else if (clkEn)
    begin
      if (flush)
      begin
        wrPtr_r <= {PTR_W{1'b0}};
        rdPtr_r <= {PTR_W{1'b0}};
        count_r <= {(PTR_W+1){1'b0}};
        used_r  <= 16'h0000;
      end
      else
      begin
        if (pushOk)
          wrPtr_r <= wrPtr_r + {{(PTR_W-1){1'b0}}, 1'b1};
        if (popOk)
          rdPtr_r <= rdPtr_r + {{(PTR_W-1){1'b0}}, 1'b1};
        if (pushOk && !popOk)
          count_r <= count_r + {{PTR_W{1'b0}}, 1'b1};
        else if (popOk && !pushOk)
          count_r <= count_r - {{PTR_W{1'b0}}, 1'b1};
        used_r <= used_nxt;
      end
    end
  end

endmodule // ffc_charge_q

// *** sim/ffc_top_asserts.sv ***
// port checker for the frame fifo controller
// assumes bind into ffc_top, clkEn held high by the bench
`timescale 1ns/1ps

module ffc_top_asserts (
  // clock, reset
  input wire        clk_sys,
  input wire        sys_rst,
  // register bus
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire        avs_waitrequest,
  // mac and status
  input wire        macTxReq,
  input wire        macTxDone,
  input wire        macTxRetry,
  input wire        halfDuplex,
  input wire        txStart_r,
  input wire        txActive_r,
  input wire        txDiscard_r,
  input wire        usbInFlush_r,
  input wire        pauseReq_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  start_cause_a: assert property (txStart_r |-> txActive_r && $past(macTxReq) && !$past(txActive_r))
    else $error("start without request");
  active_hold_a: assert property (txActive_r && !macTxDone && !macTxRetry |=> txActive_r)
    else $error("frame cut short");
  done_drop_a: assert property (txActive_r && macTxDone |=> !txActive_r && !txStart_r)
    else $error("frame not closed on done");
  discard_cause_a: assert property (txDiscard_r |-> $past(macTxRetry) && $past(halfDuplex) && !txActive_r)
    else $error("discard without retry");
  flush_cause_a: assert property (usbInFlush_r |-> $past(avs_write, 2) && $past(avs_address, 2) == 8'hc4
    && $past(avs_writedata[30], 2))
    else $error("flush without reset write");
  flush_pulse_a: assert property (usbInFlush_r |=> !usbInFlush_r)
    else $error("flush pulse too long");

  cover property (txStart_r);
  cover property (txDiscard_r);
  cover property (usbInFlush_r);
  cover property ($rose(pauseReq_r));
endmodule // ffc_top_asserts

bind ffc_top ffc_top_asserts u_chk (.*);

// *** sim/ffc_mac_model.sv ***
// mac transmit partner: asks for frames, then finishes or retries each
// assumes txActive_r from the controller, latency chosen by the bench
`timescale 1ns/1ps

module ffc_mac_model (
  // clock, reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  // bench control
  input  wire [3:0] macLat,
  input  wire       doRetry,
  // controller side
  input  wire       txActive_r,
  output reg        macTxReq,
  output reg        macTxDone,
  output reg        macTxRetry
);
  reg [3:0] cnt_r;

  // retries keep coming while the frame stays active, like a busy wire
  always @(posedge clk_sys)
  begin
    macTxDone <= 1'b0;
    macTxRetry <= 1'b0;
    macTxReq <= !sys_rst;
    if (sys_rst || !txActive_r || macTxDone || macTxRetry)
      cnt_r <= 4'h0;
    else if (cnt_r == macLat)
    begin
      cnt_r <= 4'h0;
      macTxDone <= !doRetry;
      macTxRetry <= doRetry;
    end
    else
      cnt_r <= cnt_r + 4'h1;
  end
endmodule // ffc_mac_model

// *** sim/tb_ffc_top.sv ***
// self-checking bench for ffc_top with a behavioural occupancy model
// assumes ffc_mac_model on the mac side, bench drives usb side and bus
`timescale 1ns/1ps

module tb_ffc_top;
  reg         clk_sys = 1'b0;
  reg         sys_rst = 1'b1;
  reg         clkEn = 1'b1;
  reg  [7:0]  avs_address = 8'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [3:0]  avs_byteenable = 4'hf;
  reg  [15:0] usbOutStageBytes = 16'h0;
  reg  [15:0] usbInStageBytes = 16'h0;
  reg         txFrameWr = 1'b0;
  reg  [13:0] txFrameLen = 14'h0;
  reg  [7:0]  txFrameExtra = 8'h0;
  reg         rxFrameWr = 1'b0;
  reg  [13:0] rxFrameLen = 14'h0;
  reg  [7:0]  rxFrameExtra = 8'h0;
  reg         rxFrameRd = 1'b0;
  reg         halfDuplex = 1'b0;
  reg         doRetry = 1'b0;
  reg  [3:0]  macLat = 4'h2;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, txWrReady_r, usbInFlush_r, macTxReq, macTxDone, macTxRetry;
  wire        txStart_r, txActive_r, txDiscard_r, rxWrReady_r, pauseReq_r;
  reg  [31:0] seed = 32'd98935;
  reg  [31:0] rd;
  int         fail_count = 0, samples_checked = 0, starts = 0, discards = 0, flushes = 0;
  int         txSum, rxSum, i, k, c;
  int         rxQ[$];
  bit         pause;

  ffc_top u_dut (.*);
  ffc_mac_model u_mac (.*);

  initial forever #2 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    starts += (txStart_r === 1'b1);
    discards += (txDiscard_r === 1'b1);
    flushes += (usbInFlush_r === 1'b1);
  end

  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic [15:0] sat(input int v);
    sat = (v > 65535) ? 16'hffff : v[15:0];
  endfunction

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask

  // hold the request until waitrequest is seen low, then release
  task automatic bus(input bit wr, input [7:0] a, input [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    // only the watchdog ends a wait that never gets an answer
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdchk(input [7:0] a, input [31:0] exp);
    bus(0, a, 32'h0);
    chk(rd, exp);
  endtask

  // m: 0 tx store, 1 rx store, 2 rx drain; c returns the byte charge
  task automatic frame(input int m, output int c);
    seed = lfsr(seed);
    txFrameLen <= {4'h0, seed[9:0]};
    rxFrameLen <= {4'h0, seed[9:0]};
    txFrameExtra <= {4'h0, seed[15:12]};
    rxFrameExtra <= {4'h0, seed[15:12]};
    c = ((seed[9:0] + 3) & ~3) + seed[15:12];
    txFrameWr <= (m == 0);
    rxFrameWr <= (m == 1);
    rxFrameRd <= (m == 2);
    @(posedge clk_sys);
    txFrameWr <= 1'b0;
    rxFrameWr <= 1'b0;
    rxFrameRd <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_tx(input int n);
    for (k = 0; k < 400 && (starts < n || txActive_r !== 1'b0); k++)
      @(posedge clk_sys);
  endtask

  task automatic wait_active;
    for (k = 0; k < 50 && txActive_r !== 1'b1; k++)
      @(posedge clk_sys);
  endtask

  initial
  begin
    #100000;
    fail_count++;
    final_report;
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    seed = lfsr(seed);
    usbOutStageBytes <= seed[15:0];
    usbInStageBytes <= seed[31:16];
    @(posedge clk_sys);
    rdchk(8'hc4, 32'h0);
    rdchk(8'hc8, 32'h17);
    rdchk(8'hcc, 32'h17);
    rdchk(8'he0, 32'h0);
    seed = lfsr(seed);
    bus(1, 8'hc8, seed);
    rdchk(8'hc8, seed & 32'h7f);
    bus(1, 8'hcc, seed);
    rdchk(8'hcc, seed & 32'h3f);
    bus(1, 8'hd0, seed);
    rdchk(8'hd0, seed & 32'h7f7f);
    bus(1, 8'hd4, seed);
    rdchk(8'hd4, {sat(usbOutStageBytes), usbOutStageBytes});
    bus(1, 8'hc8, 32'h17);
    bus(1, 8'hcc, 32'h0);
    // frames wait while transmit is off, tx sized to 512 bytes
    txSum = 0;
    for (i = 0; i < 3; i++)
    begin
      frame(0, c);
      txSum += c;
    end
    repeat (20) @(posedge clk_sys);
    chk(starts, 0);
    rdchk(8'hc4, txSum);
    rdchk(8'hd8, {sat(usbInStageBytes + txSum), usbInStageBytes});
    chk(txWrReady_r, txSum < 512);
    bus(1, 8'hcc, 32'h17);
    chk(txWrReady_r, 1);
    bus(1, 8'hc4, 32'h80000000);
    wait_tx(3);
    chk(starts, 3);
    rdchk(8'hc4, 32'h80000000);
    // disable with a slow frame in flight
    macLat <= 4'hc;
    frame(0, c);
    wait_active;
    bus(1, 8'hc4, 32'h0);
    rdchk(8'hc4, c);
    wait_tx(4);
    rdchk(8'hc4, 32'h00100000);
    bus(1, 8'hc4, 32'h00100000);
    rdchk(8'hc4, 32'h0);
    // half duplex retry after disable
    halfDuplex <= 1'b1;
    doRetry <= 1'b1;
    macLat <= 4'h3;
    bus(1, 8'hc4, 32'h80000000);
    frame(0, c);
    wait_active;
    bus(1, 8'hc4, 32'h0);
    wait_tx(5);
    repeat (8) @(posedge clk_sys);
    chk(discards, 1);
    chk(starts, 5);
    rdchk(8'hc4, 32'h00100000);
    halfDuplex <= 1'b0;
    doRetry <= 1'b0;
    bus(1, 8'hc4, 32'h00100000);
    // transmit reset while disabled, frames pending
    frame(0, c);
    frame(0, c);
    bus(1, 8'hc4, 32'h40000000);
    repeat (3) @(posedge clk_sys);
    chk(flushes, 1);
    rdchk(8'hc4, 32'h0);
    // watermarks: off at 1, on at 3 units
    bus(1, 8'hd0, 32'h0103);
    repeat (3) @(posedge clk_sys);
    pause = 0;
    rxSum = 0;
    chk(pauseReq_r, pause);
    for (i = 0; i < 30; i++)
    begin
      seed = lfsr(seed);
      if ((seed[16] || rxQ.size() == 0) && rxQ.size() < 8)
      begin
        frame(1, c);
        rxQ.push_back(c);
        rxSum += c;
      end
      else
      begin
        frame(2, c);
        rxSum -= rxQ.pop_front();
      end
      repeat (2) @(posedge clk_sys);
      if (!pause && (rxSum >> 9) >= 3)
        pause = 1;
      else if (pause && (rxSum >> 9) <= 1)
        pause = 0;
      chk(pauseReq_r, pause);
      chk(rxWrReady_r, rxSum < 12288);
      rdchk(8'hd4, {sat(usbOutStageBytes + rxSum), usbOutStageBytes});
    end
    final_report;
  end
endmodule // tb_ffc_top
